// ==== core/fesr_defs.svh ====
// Constants for the flash error status and ECC report block.
// Assumes a 10 MHz core clock; command codes are this block's own encoding.
`ifndef FESR_DEFS_SVH
`define FESR_DEFS_SVH
// Operation status word bit positions
`define FESR_SR_READY 7
`define FESR_SR_ESUSP 6
`define FESR_SR_ERASE 5
`define FESR_SR_PROG 4
`define FESR_SR_WBA 3
`define FESR_SR_PSUSP 2
`define FESR_SR_PROT 1
`define FESR_SR_RESET 8'h80
// ECC unit status word bit positions
`define FESR_ECC_DBL 4
`define FESR_ECC_COR 3
`define FESR_ECC_RESET 16'h0000
// Volatile configuration bit that disables strobe stall when 1
`define FESR_VCW_STALL_DIS 2
// Command codes carried in the first byte of a link frame
`define FESR_CMD_RD_SR 8'h70
`define FESR_CMD_CLR_SR 8'h71
`define FESR_CMD_RESET 8'hF0
`define FESR_CMD_PROG 8'hA0
`define FESR_CMD_ERASE 8'h30
`define FESR_CMD_BLANK 8'h33
`define FESR_CMD_UNLOCK 8'h29
`define FESR_CMD_WBUF 8'h25
`define FESR_CMD_WBA_RST 8'hF1
`define FESR_CMD_ECC_ENTRY 8'h75
`define FESR_CMD_ECC_READ 8'h76
`define FESR_CMD_EXIT 8'h90
`define FESR_CMD_ARRAY_RD 8'h0B
// Protection error busy time, least figure, and its cycle count
`define FESR_PROT_BUSY_NS 20000
`define FESR_CLK_NS 100
`define FESR_PROT_CYC ((`FESR_PROT_BUSY_NS + `FESR_CLK_NS - 1) / `FESR_CLK_NS)
`endif

// ==== core/fesr_pkg.sv ====
// Types shared by the flash error status and ECC report block.
// Assumes fesr_defs.svh supplies the numeric constants.
package fesr_pkg;
  typedef enum logic [2:0] {ST_READY, ST_RUN, ST_OP_ERR, ST_PROT_BUSY, ST_WBA} fesr_state_e;
  typedef enum logic [2:0] {OP_PROG, OP_ERASE, OP_BLANK, OP_UNLOCK, OP_WBUF, OP_NONE} fesr_op_e;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg;
  } fesr_frame_s;
  typedef struct packed {
    logic vld;
    logic [7:0] unit;
    logic off;
    logic cor_data;
    logic cor_code;
    logic dbl;
  } fesr_ecc_evt_s;
  typedef struct packed {
    logic stall;
    logic [15:0] word;
  } fesr_reply_s;
endpackage

// ==== core/fesr_core.sv ====
// Error status reporting, command gating and ECC status for the algorithm controller.
// Assumes the array engine and ECC read path share the core clock; the link
// runs on its own clock and its pins are synchronised here.
//
// Functional notes
// RULE_01: A failed program, erase, blank check or unlock holds error status, bit 7 set.
// RULE_02: Operation error shows bit 5 for erase/blank, bit 4 for program/password.
// RULE_03: Reset or status clear leaves operation error; normal commands resume.
// RULE_04: Under operation error only status read, reset and status clear act.
// RULE_05: Protected target aborts; busy at least 20 us with bit 7 low.
// RULE_06: During protection busy only status read is served.
// RULE_07: After protection busy bit 1 set, bit 5 erase, bit 4 program.
// RULE_08: After protection busy any command or array read is accepted.
// RULE_09: A new program clears bit 4; a new erase clears bit 6.
// RULE_10: Buffer write failure holds abort: bits 7, 4, 3 set; 5, 2, 1 clear.
// RULE_11: In buffer abort only status read, abort reset and clear act.
// RULE_12: Abort reset or status clear clears status and returns to normal.
// RULE_13: Array reads while busy still toggle the strobe with meaningless data.
// RULE_14: When enabled, interrupt output pulses on any one- or two-bit ECC event.
// RULE_15: In stall mode a two-bit error read stops the strobe; host times it out.
// RULE_16: ECC read command plus unit address returns that unit's 16-bit status.
// RULE_17: Double and correction flags are global, not per unit.
// RULE_18: Unit bits: 0 ECC off, 1 data corrected, 2 check code corrected.
// RULE_19: Correction flag holds until overlay exit; current read may set it.
// RULE_20: Double flag holds until overlay exit; lower bits then unreliable.
// RULE_21: Reserved bits 15 to 5 carry no meaning; they read as zero here.
// RULE_22: Hardware reset, reset or exit from the overlay zeroes ECC status.
// RULE_23: Stall enabled by config bit at 0 holds strobe low until chip select high.
`timescale 1ns/100ps
`include "fesr_defs.svh"
module fesr_core
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic [7:0] link_dq_i,
  output logic [7:0] link_dq_o,
  output logic link_dq_oe_n,
  output logic read_data_strobe_o,
  output logic read_data_strobe_oe_n,
  output logic eng_start,
  output fesr_pkg::fesr_op_e eng_op,
  input wire logic eng_done,
  input wire logic eng_fail,
  input wire logic eng_erase_susp,
  input wire logic sector_locked,
  input wire logic [15:0] array_rdata,
  input wire fesr_pkg::fesr_ecc_evt_s ecc_evt,
  input wire logic ecc_irq_en,
  input wire logic [15:0] volatile_config_word,
  output logic ecc_int_n,
  output logic [7:0] op_status_word,
  output logic ecc_overlay
);

  // Map a command byte to the embedded operation it starts
  function automatic fesr_pkg::fesr_op_e cmd_op(input logic [7:0] c);
    unique case (c)
      `FESR_CMD_PROG: cmd_op = fesr_pkg::OP_PROG;
      `FESR_CMD_ERASE: cmd_op = fesr_pkg::OP_ERASE;
      `FESR_CMD_BLANK: cmd_op = fesr_pkg::OP_BLANK;
      `FESR_CMD_UNLOCK: cmd_op = fesr_pkg::OP_UNLOCK;
      `FESR_CMD_WBUF: cmd_op = fesr_pkg::OP_WBUF;
      default: cmd_op = fesr_pkg::OP_NONE;
    endcase
  endfunction

  // Operations that write data, hence subject to sector protection
  function automatic logic changes_data(input fesr_pkg::fesr_op_e o);
    changes_data = (o == fesr_pkg::OP_PROG) || (o == fesr_pkg::OP_ERASE) ||
      (o == fesr_pkg::OP_WBUF);
  endfunction

  // Commands that expect a data phase back on the link
  function automatic logic is_read(input logic [7:0] c);
    is_read = (c == `FESR_CMD_RD_SR) || (c == `FESR_CMD_ECC_READ) ||
      (c == `FESR_CMD_ARRAY_RD);
  endfunction

  // ---------------- Link clock domain ----------------
  logic [1:0] lrst_q;
  logic lcs_q1, lcs_q2;
  logic [7:0] ldq_q1, ldq_q2;
  logic [1:0] lcnt_q;
  fesr_pkg::fesr_frame_s lfr_q;
  logic lft_q;
  logic lrt_q1, lrt_q2, lrt_q3;
  logic [1:0] lph_q;
  logic [7:0] ldq_o_q;
  logic ldq_oe_n_q, lrds_q, lrds_oe_n_q;
  fesr_pkg::fesr_reply_s reply_q;
  logic rtgl_q;

  // Reset release and pins pass two flops before link logic reads them
  always_ff @(posedge link_clk)
  begin
    lrst_q <= {lrst_q[0], rstn};
    lcs_q1 <= link_cs_n;
    lcs_q2 <= lcs_q1;
    ldq_q1 <= link_dq_i;
    ldq_q2 <= ldq_q1;
    lrt_q1 <= rtgl_q;
    lrt_q2 <= lrt_q1;
    lrt_q3 <= lrt_q2;
  end

  // Frame capture: byte 0 command, byte 1 argument, then a toggle to the core
  always_ff @(posedge link_clk)
  begin
    if (!lrst_q[1])
    begin
      lcnt_q <= 2'h0;
      lfr_q <= '0;
      lft_q <= 1'b0;
    end
    else if (lcs_q2)
      lcnt_q <= 2'h0;
    else if (lcnt_q == 2'h0)
    begin
      lfr_q.cmd <= ldq_q2;
      lcnt_q <= 2'h1;
    end
    else if (lcnt_q == 2'h1)
    begin
      lfr_q.arg <= ldq_q2;
      lft_q <= ~lft_q;
      lcnt_q <= 2'h2;
    end
  end

  // Data phase: strobe low until the core answers, then two strobed bytes
  always_ff @(posedge link_clk)
  begin
    if (!lrst_q[1] || lcs_q2)
    begin
      lph_q <= 2'h0;
      ldq_o_q <= 8'h00;
      ldq_oe_n_q <= 1'b1;
      lrds_q <= 1'b0;
      lrds_oe_n_q <= 1'b1; // [RULE_23] stall released once chip select is high
    end
    else
    begin
      unique case (lph_q)
        2'h0:
        begin
          if (lcnt_q == 2'h2 && is_read(lfr_q.cmd))
            lrds_oe_n_q <= 1'b0;
          if (lcnt_q == 2'h2 && is_read(lfr_q.cmd) && (lrt_q2 ^ lrt_q3))
          begin
            if (reply_q.stall)
              lph_q <= 2'h3; // [RULE_15] [RULE_23] strobe parked low, no toggling
            else
            begin
              ldq_o_q <= reply_q.word[15:8]; // [RULE_13] strobe toggles even for junk data
              ldq_oe_n_q <= 1'b0;
              lrds_q <= 1'b1;
              lph_q <= 2'h1;
            end
          end
        end
        2'h1:
        begin
          ldq_o_q <= reply_q.word[7:0];
          lrds_q <= 1'b0;
          lph_q <= 2'h2;
        end
        2'h2:
        begin
          ldq_oe_n_q <= 1'b1;
          lph_q <= 2'h3;
        end
        2'h3:
          lrds_q <= 1'b0;
      endcase
    end
  end

  assign link_dq_o = ldq_o_q;
  assign link_dq_oe_n = ldq_oe_n_q;
  assign read_data_strobe_o = lrds_q;
  assign read_data_strobe_oe_n = lrds_oe_n_q;

  // ---------------- Core clock domain ----------------
  logic cft_q1, cft_q2, cft_q3;
  fesr_pkg::fesr_state_e st_q;
  logic [7:0] tmr_q;
  logic [7:0] sr_q;
  logic ovl_q, dbl_q, cor_q;
  logic [2:0] ecc_tab_q [256];
  logic eng_start_q, int_n_q;
  fesr_pkg::fesr_op_e op_q;
  logic new_frame, go_op, go_prot, go_clr, go_exit, go_entry, prot_end;
  logic [7:0] cmd;
  fesr_pkg::fesr_op_e cop;
  logic [15:0] ecc_word;
  logic [2:0] unit_bits;

  // Frame toggle crossing; the frame register holds still until the next frame
  always_ff @(posedge clock)
  begin
    cft_q1 <= lft_q;
    cft_q2 <= cft_q1;
    cft_q3 <= cft_q2;
  end

  // Command decode and gating per controller state
  always_comb
  begin
    new_frame = cft_q2 ^ cft_q3;
    cmd = lfr_q.cmd;
    cop = cmd_op(cmd);
    go_op = new_frame && st_q == fesr_pkg::ST_READY && cop != fesr_pkg::OP_NONE &&
      !(sector_locked && changes_data(cop)); // [RULE_08]
    go_prot = new_frame && st_q == fesr_pkg::ST_READY && changes_data(cop) &&
      sector_locked; // [RULE_05]
    go_clr = new_frame && (
      (st_q == fesr_pkg::ST_OP_ERR &&
        (cmd == `FESR_CMD_RESET || cmd == `FESR_CMD_CLR_SR)) || // [RULE_03] [RULE_04]
      (st_q == fesr_pkg::ST_WBA &&
        (cmd == `FESR_CMD_WBA_RST || cmd == `FESR_CMD_CLR_SR)) || // [RULE_11] [RULE_12]
      (st_q == fesr_pkg::ST_READY && cmd == `FESR_CMD_CLR_SR));
    go_exit = new_frame && ovl_q && ((st_q == fesr_pkg::ST_READY &&
      (cmd == `FESR_CMD_EXIT || cmd == `FESR_CMD_RESET)) ||
      (st_q == fesr_pkg::ST_OP_ERR && cmd == `FESR_CMD_RESET)); // [RULE_22]
    go_entry = new_frame && st_q == fesr_pkg::ST_READY && cmd == `FESR_CMD_ECC_ENTRY;
    prot_end = st_q == fesr_pkg::ST_PROT_BUSY && tmr_q == 8'h01;
    unit_bits = ecc_tab_q[lfr_q.arg]; // [RULE_16] [RULE_18]
    ecc_word = `FESR_ECC_RESET; // [RULE_21] reserved bits read as zero
    ecc_word[`FESR_ECC_DBL] = dbl_q; // [RULE_17] [RULE_20]
    ecc_word[`FESR_ECC_COR] = cor_q | unit_bits[1] | unit_bits[2]; // [RULE_19]
    ecc_word[2:0] = unit_bits;
  end

  // Controller state; anything not listed per state is ignored
  always_ff @(posedge clock)
  begin
    if (!rstn)
      st_q <= fesr_pkg::ST_READY;
    else
    begin
      unique case (st_q)
        fesr_pkg::ST_READY:
          if (go_prot)
            st_q <= fesr_pkg::ST_PROT_BUSY;
          else if (go_op)
            st_q <= fesr_pkg::ST_RUN;
        fesr_pkg::ST_RUN:
          if (eng_done && eng_fail && op_q == fesr_pkg::OP_WBUF)
            st_q <= fesr_pkg::ST_WBA; // [RULE_10]
          else if (eng_done && eng_fail)
            st_q <= fesr_pkg::ST_OP_ERR; // [RULE_01]
          else if (eng_done)
            st_q <= fesr_pkg::ST_READY;
        fesr_pkg::ST_OP_ERR, fesr_pkg::ST_WBA:
          if (go_clr)
            st_q <= fesr_pkg::ST_READY; // [RULE_03] [RULE_12]
        fesr_pkg::ST_PROT_BUSY:
          if (prot_end)
            st_q <= fesr_pkg::ST_READY; // [RULE_06] only status reads served meanwhile
      endcase
    end
  end

  // Protection busy timer, least figure so the host never waits past the limit
  always_ff @(posedge clock)
  begin
    if (!rstn)
      tmr_q <= 8'h00;
    else if (go_prot)
      tmr_q <= 8'(`FESR_PROT_CYC); // [RULE_05]
    else if (tmr_q != 8'h00)
      tmr_q <= tmr_q - 8'h01;
  end

  // Engine launch and the operation kind kept for error classification
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      eng_start_q <= 1'b0;
      op_q <= fesr_pkg::OP_NONE;
    end
    else
    begin
      eng_start_q <= go_op;
      if (go_op || go_prot)
        op_q <= cop;
    end
  end

  // Operation status word; later assignments win, so events beat a clear
  always_ff @(posedge clock)
  begin
    if (!rstn)
      sr_q <= `FESR_SR_RESET;
    else
    begin
      if (go_clr)
        sr_q <= {1'b1, sr_q[`FESR_SR_ESUSP], 6'h00};
      if (go_op || go_prot)
      begin
        sr_q[`FESR_SR_READY] <= 1'b0; // [RULE_05]
        if (cop == fesr_pkg::OP_PROG || cop == fesr_pkg::OP_WBUF)
          sr_q[`FESR_SR_PROG] <= 1'b0; // [RULE_09]
        if (cop == fesr_pkg::OP_ERASE)
          sr_q[`FESR_SR_ESUSP] <= 1'b0; // [RULE_09]
      end
      if (st_q == fesr_pkg::ST_RUN && eng_done)
      begin
        sr_q[`FESR_SR_READY] <= 1'b1;
        sr_q[`FESR_SR_PSUSP] <= 1'b0;
        sr_q[`FESR_SR_PROT] <= 1'b0;
        if (eng_fail && op_q == fesr_pkg::OP_WBUF)
        begin
          sr_q[`FESR_SR_ERASE] <= 1'b0; // [RULE_10]
          sr_q[`FESR_SR_PROG] <= 1'b1;
          sr_q[`FESR_SR_WBA] <= 1'b1;
        end
        else if (eng_fail)
        begin
          sr_q[`FESR_SR_ERASE] <= op_q == fesr_pkg::OP_ERASE ||
            op_q == fesr_pkg::OP_BLANK; // [RULE_02]
          sr_q[`FESR_SR_PROG] <= op_q == fesr_pkg::OP_PROG ||
            op_q == fesr_pkg::OP_UNLOCK; // [RULE_02]
        end
      end
      if (prot_end)
      begin
        sr_q[`FESR_SR_READY] <= 1'b1; // [RULE_07]
        sr_q[`FESR_SR_PROT] <= 1'b1;
        sr_q[`FESR_SR_PSUSP] <= 1'b0;
        sr_q[`FESR_SR_ERASE] <= op_q == fesr_pkg::OP_ERASE;
        sr_q[`FESR_SR_PROG] <= op_q != fesr_pkg::OP_ERASE;
      end
      if (eng_erase_susp)
        sr_q[`FESR_SR_ESUSP] <= 1'b1;
    end
  end

  // ECC overlay flag
  always_ff @(posedge clock)
  begin
    if (!rstn || go_exit)
      ovl_q <= 1'b0;
    else if (go_entry)
      ovl_q <= 1'b1;
  end

  // ECC flags and per-unit table; a new event in the exit cycle survives it
  always_ff @(posedge clock)
  begin
    if (!rstn || go_exit)
    begin
      dbl_q <= 1'b0; // [RULE_22]
      cor_q <= 1'b0;
      for (int i = 0; i < 256; i++)
        ecc_tab_q[i] <= 3'h0;
    end
    if (rstn && ecc_evt.vld)
    begin
      ecc_tab_q[ecc_evt.unit] <= {ecc_evt.cor_code, ecc_evt.cor_data, ecc_evt.off}; // [RULE_18]
      if (ecc_evt.dbl)
        dbl_q <= 1'b1; // [RULE_20]
      if (ecc_evt.cor_data || ecc_evt.cor_code)
        cor_q <= 1'b1; // [RULE_19]
    end
  end

  // Interrupt pulse, low for one cycle per enabled corrected or double ECC event
  always_ff @(posedge clock)
  begin
    if (!rstn)
      int_n_q <= 1'b1;
    else
      int_n_q <= !(ecc_irq_en && ecc_evt.vld &&
        (ecc_evt.dbl || ecc_evt.cor_data || ecc_evt.cor_code)); // [RULE_14]
  end

  // Reply word for every frame; held until the next one so the link can copy it
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      reply_q <= '0;
      rtgl_q <= 1'b0;
    end
    else if (new_frame)
    begin
      rtgl_q <= ~rtgl_q;
      reply_q.stall <= cmd == `FESR_CMD_ARRAY_RD && ecc_evt.vld && ecc_evt.dbl &&
        !volatile_config_word[`FESR_VCW_STALL_DIS]; // [RULE_15] [RULE_23]
      if (cmd == `FESR_CMD_RD_SR)
        reply_q.word <= {8'h00, sr_q}; // [RULE_04] [RULE_06] [RULE_11]
      else if (cmd == `FESR_CMD_ECC_READ && st_q == fesr_pkg::ST_READY)
        reply_q.word <= ecc_word; // [RULE_16]
      else if (cmd == `FESR_CMD_ARRAY_RD && st_q == fesr_pkg::ST_READY)
        reply_q.word <= array_rdata;
      else
        reply_q.word <= 16'h0000; // [RULE_13] no meaningful data while busy
    end
  end

  assign eng_start = eng_start_q;
  assign eng_op = op_q;
  assign ecc_int_n = int_n_q;
  assign op_status_word = sr_q;
  assign ecc_overlay = ovl_q;

endmodule

// ==== verif/fesr_core_properties.sv ====
// Assertions on the status, interrupt and link outputs of fesr_core.
// Assumes it is bound to fesr_core and sees only that module's ports.
`timescale 1ns/100ps
`include "fesr_defs.svh"
module fesr_core_properties
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic link_dq_oe_n,
  input wire logic read_data_strobe_o,
  input wire logic read_data_strobe_oe_n,
  input wire logic eng_done,
  input wire logic eng_fail,
  input wire fesr_pkg::fesr_ecc_evt_s ecc_evt,
  input wire logic ecc_irq_en,
  input wire logic ecc_int_n,
  input wire logic [7:0] op_status_word
);
  localparam int PROT_MIN = `FESR_PROT_CYC;
  localparam int PROT_MAX = 1000;
  logic [10:0] low_cnt_q;
  // Cycles spent not ready; saturates so a hang cannot wrap round
  always_ff @(posedge clock)
  begin
    if (!rstn || op_status_word[7])
      low_cnt_q <= 11'h000;
    else if (low_cnt_q != 11'h7FF)
      low_cnt_q <= low_cnt_q + 11'h001;
  end
  sequence s_prot_done;
    $rose(op_status_word[7]) && op_status_word[1];
  endsequence
  sequence s_low_byte;
    !read_data_strobe_o && !link_dq_oe_n ##1 link_dq_oe_n;
  endsequence
  a_prot_busy: assert property (@(posedge clock) disable iff (!rstn) s_prot_done |->
    low_cnt_q >= PROT_MIN && low_cnt_q <= PROT_MAX) else $error("protection busy length wrong");
  a_prot_bits: assert property (@(posedge clock) disable iff (!rstn) s_prot_done |->
    !op_status_word[2] && (op_status_word[5] ^ op_status_word[4]))
    else $error("protection status bits wrong");
  a_fail_status: assert property (@(posedge clock) disable iff (!rstn)
    eng_done && eng_fail |=> op_status_word[7] && !op_status_word[2] && !op_status_word[1]
    && (op_status_word[5] || op_status_word[4])) else $error("failure status wrong");
  a_wba_bits: assert property (@(posedge clock) disable iff (!rstn)
    op_status_word[7] && op_status_word[3] |-> op_status_word[4] && !op_status_word[5]
    && !op_status_word[2] && !op_status_word[1]) else $error("buffer abort bits wrong");
  a_int_event: assert property (@(posedge clock) disable iff (!rstn)
    ecc_evt.vld && ecc_irq_en && (ecc_evt.cor_data || ecc_evt.cor_code || ecc_evt.dbl)
    |=> !ecc_int_n) else $error("interrupt missing after ecc event");
  a_int_cause: assert property (@(posedge clock) disable iff (!rstn)
    $fell(ecc_int_n) |-> $past(ecc_evt.vld) && $past(ecc_irq_en))
    else $error("interrupt without enabled event");
  a_reply_pair: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(read_data_strobe_o) && !link_dq_oe_n |=> s_low_byte)
    else $error("reply byte pair broken");
  a_strobe_idle: assert property (@(posedge link_clk) disable iff (!rstn)
    link_cs_n [*4] |-> read_data_strobe_oe_n && link_dq_oe_n)
    else $error("link driven after deselect");
endmodule

// ==== verif/fesr_host_model.sv ====
// Host controller model: makes the link clock only inside its tasks, in frames, in the idle ticks after them and in the reset ticks.
// Assumes the device samples command bytes on rising link edges.
`timescale 1ns/100ps
module fesr_host_model
(
  output logic link_clk,
  output logic link_cs_n,
  output logic [7:0] link_dq_i,
  input wire logic [7:0] link_dq_o,
  input wire logic link_dq_oe_n,
  input wire logic read_data_strobe_o
);
  // Idle lines from time zero
  initial
  begin
    link_clk = 1'b0;
    link_cs_n = 1'b1;
    link_dq_i = 8'h00;
  end
  task automatic ticks(input int n);
    repeat (n)
    begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  endtask
  // Command byte, then argument; released bus toggles so stale data never looks valid
  task automatic frame(input logic [7:0] c, input logic [7:0] a, output logic [15:0] w,
    output logic got);
    int ph;
    ph = 0;
    got = 1'b0;
    w = 16'h0000;
    link_cs_n = 1'b0;
    link_dq_i = c;
    ticks(1);
    link_dq_i = a;
    repeat (24)
    begin
      #62.5;
      if (ph == 1)
      begin
        w[7:0] = link_dq_oe_n ? ~link_dq_o : link_dq_o; // Released bus must not pass as data
        got = 1'b1;
        ph = 2;
      end
      if (ph == 0 && read_data_strobe_o === 1'b1 && link_dq_oe_n === 1'b0)
      begin
        w[15:8] = link_dq_o;
        ph = 1;
      end
      link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
      link_dq_i = ~link_dq_i;
    end
    link_cs_n = 1'b1;
    ticks(4);
  endtask
endmodule

// ==== verif/flash_error_status_ecc_report_tb.sv ====
// Self-checking bench for fesr_core with a host model on the link.
// Assumes the engine and ECC path are played by the bench on the core clock.
`timescale 1ns/100ps
`include "fesr_defs.svh"
module flash_error_status_ecc_report_tb;
  logic clock;
  logic rstn;
  logic eng_done;
  logic eng_fail;
  logic sector_locked;
  logic ecc_irq_en;
  logic [15:0] array_rdata;
  logic esusp;
  logic [15:0] vcw;
  fesr_pkg::fesr_ecc_evt_s ecc_evt;
  wire logic link_clk;
  wire logic link_cs_n;
  wire logic [7:0] link_dq_i;
  wire logic [7:0] link_dq_o;
  wire logic link_dq_oe_n;
  wire logic strobe;
  wire logic strobe_oe_n;
  wire logic eng_start;
  wire fesr_pkg::fesr_op_e eng_op;
  wire logic ecc_int_n;
  wire logic [7:0] sr;
  wire logic ecc_overlay;
  int failures = 0;
  int check_count = 0;
  int starts = 0;
  logic [15:0] w;
  logic got;
  fesr_host_model u_host (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_dq_i(link_dq_i),
    .link_dq_o(link_dq_o), .link_dq_oe_n(link_dq_oe_n), .read_data_strobe_o(strobe));
  // Stall stays disabled until the stall scenario clears the config bit
  fesr_core u_dut (.clock(clock), .rstn(rstn), .link_clk(link_clk), .link_cs_n(link_cs_n),
    .link_dq_i(link_dq_i), .link_dq_o(link_dq_o), .link_dq_oe_n(link_dq_oe_n),
    .read_data_strobe_o(strobe), .read_data_strobe_oe_n(strobe_oe_n), .eng_start(eng_start),
    .eng_op(eng_op), .eng_done(eng_done), .eng_fail(eng_fail), .eng_erase_susp(esusp),
    .sector_locked(sector_locked), .array_rdata(array_rdata), .ecc_evt(ecc_evt),
    .ecc_irq_en(ecc_irq_en), .volatile_config_word(vcw), .ecc_int_n(ecc_int_n),
    .op_status_word(sr), .ecc_overlay(ecc_overlay));
  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Frames spaced 2.5 us so the core crossing settles between them
  task automatic cmd(input logic [7:0] c, input logic [7:0] a);
    u_host.frame(c, a, w, got);
    cyc(25);
  endtask
  task automatic op_cmd(input logic [7:0] c, input int n);
    int s;
    s = starts;
    cmd(c, 8'h00);
    check("starts", 16'(starts - s), 16'(n));
  endtask
  task automatic finish_op(input logic fail);
    eng_done = 1'b1;
    eng_fail = fail;
    cyc(1);
    eng_done = 1'b0;
    eng_fail = 1'b0;
    cyc(3);
  endtask
  task automatic t_op_err();
    logic [7:0] ops [4] = '{`FESR_CMD_PROG, `FESR_CMD_ERASE, `FESR_CMD_BLANK, `FESR_CMD_UNLOCK};
    logic [7:0] exs [4] = '{8'h90, 8'hA0, 8'hA0, 8'h90};
    logic [7:0] clr [4] = '{`FESR_CMD_CLR_SR, `FESR_CMD_CLR_SR, `FESR_CMD_CLR_SR, `FESR_CMD_RESET};
    fesr_pkg::fesr_op_e opk [4] = '{fesr_pkg::OP_PROG, fesr_pkg::OP_ERASE, fesr_pkg::OP_BLANK,
      fesr_pkg::OP_UNLOCK};
    for (int i = 0; i < 4; i++)
    begin
      op_cmd(ops[i], 1);
      check("op kind", 16'(eng_op), 16'(opk[i]));
      finish_op(1'b1);
      check("op err", {8'h00, sr & 8'hB6}, {8'h00, exs[i]});
      op_cmd(`FESR_CMD_ERASE, 0);
      cmd(`FESR_CMD_RD_SR, 8'h00);
      check("sr read", {7'h00, got, w[7:0] & 8'hB6}, {8'h01, exs[i]});
      cmd(clr[i], 8'h00);
    end
  endtask
  task automatic t_prot();
    sector_locked = 1'b1;
    cmd(`FESR_CMD_ERASE, 8'h00);
    check("prot busy", {15'h0000, sr[7]}, 16'h0000);
    cmd(`FESR_CMD_RD_SR, 8'h00);
    check("busy read", {7'h00, got, w[7:0] & 8'h80}, 16'h0100);
    cyc(150);
    check("prot erase", {8'h00, sr & 8'hB6}, 16'h00A2);
    cmd(`FESR_CMD_CLR_SR, 8'h00);
    cmd(`FESR_CMD_PROG, 8'h00);
    cyc(200);
    check("prot prog", {8'h00, sr & 8'hB6}, 16'h0092);
    sector_locked = 1'b0;
    op_cmd(`FESR_CMD_PROG, 1);
    check("prog bit", {15'h0000, sr[4]}, 16'h0000);
    cmd(`FESR_CMD_ARRAY_RD, 8'h00);
    check("busy array", {15'h0000, got}, 16'h0001);
    finish_op(1'b0);
    cmd(`FESR_CMD_ARRAY_RD, 8'h00);
    check("array", got ? w : 16'h0000, 16'h5AC3);
    esusp = 1'b1;
    cyc(1);
    esusp = 1'b0;
    check("susp bit", {15'h0000, sr[6]}, 16'h0001);
    op_cmd(`FESR_CMD_ERASE, 1);
    check("susp clr", {15'h0000, sr[6]}, 16'h0000);
    finish_op(1'b0);
  endtask
  task automatic t_wba();
    logic [7:0] clr [2] = '{`FESR_CMD_WBA_RST, `FESR_CMD_CLR_SR};
    cmd(`FESR_CMD_CLR_SR, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      op_cmd(`FESR_CMD_WBUF, 1);
      finish_op(1'b1);
      check("wba", {8'h00, sr & 8'hBE}, 16'h0098);
      cmd(`FESR_CMD_RD_SR, 8'h00);
      check("wba read", {got, 7'h00, w[7:0] & 8'hBE}, 16'h8098);
      op_cmd(`FESR_CMD_PROG, 0);
      cmd(clr[i], 8'h00);
      check("wba clr", {8'h00, sr & 8'hBE}, 16'h0080);
    end
  endtask
  // Event kinds in order off, data corrected, code corrected, double
  task automatic evt(input logic [7:0] u, input logic [3:0] k);
    ecc_evt = {1'b1, u, k};
    cyc(1);
    check("int", {15'h0000, ecc_int_n}, {15'h0000, !(ecc_irq_en && k[2:0] != 3'h0)});
    ecc_evt.vld = 1'b0;
    cyc(2);
  endtask
  task automatic eread(input logic [7:0] u, input logic [15:0] e);
    cmd(`FESR_CMD_ECC_READ, u);
    check("ecc word", got ? (w & 16'h001F) : 16'hFFFF, e);
  endtask
  task automatic t_ecc();
    logic [7:0] ex [2] = '{`FESR_CMD_EXIT, `FESR_CMD_RESET};
    for (int i = 0; i < 2; i++)
    begin
      ecc_irq_en = (i == 0);
      cmd(`FESR_CMD_ECC_ENTRY, 8'h00);
      check("overlay", {15'h0000, ecc_overlay}, 16'h0001);
      eread(8'h03, 16'h0000);
      evt(8'h03, 4'b0100);
      evt(8'h01, 4'b1000);
      evt(8'h02, 4'b0010);
      eread(8'h03, 16'h000A);
      eread(8'h01, 16'h0009);
      eread(8'h02, 16'h000C);
      eread(8'h05, 16'h0008);
      evt(8'h07, 4'b0001);
      eread(8'h05, 16'h0018);
      cmd(ex[i], 8'h00);
      check("overlay", {15'h0000, ecc_overlay}, 16'h0000);
    end
    cmd(`FESR_CMD_ECC_ENTRY, 8'h00);
    eread(8'h03, 16'h0000);
    cmd(`FESR_CMD_EXIT, 8'h00);
  endtask
  // Double error at decode with stall on: no bytes; the next frame reads normally
  task automatic t_stall();
    vcw = 16'h0000;
    ecc_evt = {1'b1, 8'h09, 4'b0001};
    cmd(`FESR_CMD_ARRAY_RD, 8'h00);
    ecc_evt = '0;
    check("stall", {15'h0000, got}, 16'h0000);
    cmd(`FESR_CMD_ARRAY_RD, 8'h00);
    check("resume", got ? w : 16'h0000, 16'h5AC3);
    vcw = 16'h0004;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Count engine starts so refused commands show as no change
  always @(posedge clock)
    if (eng_start === 1'b1)
      starts++;
  // Watchdog well beyond the expected run of about 0.4 ms
  initial
  begin
    #3000000;
    failures++;
    complete_run();
  end
  // Link clock runs during reset so the link side resets too
  initial
  begin
    rstn = 1'b0;
    eng_done = 1'b0;
    eng_fail = 1'b0;
    sector_locked = 1'b0;
    ecc_irq_en = 1'b0;
    array_rdata = 16'h5AC3;
    esusp = 1'b0;
    vcw = 16'h0004;
    ecc_evt = '0;
    cyc(1);
    u_host.ticks(8);
    cyc(1);
    rstn = 1'b1;
    u_host.ticks(4);
    cyc(2);
    t_op_err();
    t_prot();
    t_wba();
    t_ecc();
    t_stall();
    complete_run();
  end
endmodule
bind fesr_core fesr_core_properties u_props (.clock(clock), .rstn(rstn), .link_clk(link_clk),
  .link_cs_n(link_cs_n), .link_dq_oe_n(link_dq_oe_n), .read_data_strobe_o(read_data_strobe_o),
  .read_data_strobe_oe_n(read_data_strobe_oe_n), .eng_done(eng_done), .eng_fail(eng_fail),
  .ecc_evt(ecc_evt), .ecc_irq_en(ecc_irq_en), .ecc_int_n(ecc_int_n),
  .op_status_word(op_status_word));
